// [cbsbc_host_end.sv]
// Controller end of the socket link: clock, arbiter, initiator, target, sideband
`timescale 1ns/1ps
`include "cbsbc_params.svh"
module cbsbc_host_end
	import cbsbc_pkg::*;
#(
	parameter int AbortClks = `CBSBC_ABORT_CLKS
) (
	input  wire logic        sys_clk,        // System clock, 10 MHz
	input  wire logic        rst_n,          // Synchronous reset
	cbsbc_link_if.host       lnk,            // Socket link
	input  wire logic        reqValid,       // Start an initiator transaction
	input  wire logic        reqWrite,       // Write when high, read when low
	input  wire logic        reqLock,        // Hold the bus lock for it
	input  wire logic [31:0] reqAddr,        // Target address
	input  wire logic [3:0]  reqLen,         // Words, 1 to 15
	output logic             reqBusy,        // Request held until done
	input  wire logic [31:0] wrData,         // Write words into the FIFO
	input  wire logic        wrValid,
	output logic             wrReady,
	output logic [31:0]      rdData,         // Read word
	output logic             rdValid,
	output logic             doneOk,         // Transaction ended normally
	output logic             doneAbort,      // Nobody claimed it
	output logic [31:0]      tgtAddr,        // Word written to us by the card
	output logic [31:0]      tgtData,
	output logic             tgtValid,
	output logic             parityErr,      // Bad parity on a word to us
	output logic             speakerOut,
	output logic             cardPresent,
	output cbsbc_volt_t      cardVolt,
	output logic             cardIsCardbus,
	output logic             cardIrq,
	output logic             systemError,    // Forwarded card system error
	output logic             statusChange,   // Pulse per rising status edge
	output logic             wakeUp
);
	localparam int NIn = 53;
	localparam int DivN = `CBSBC_DIV;
	// Idle pin levels: pulled-up lines high, status change and audio low
	localparam logic [NIn-1:0] SyncIdle = {{(NIn-6){1'b1}}, 2'b00, 4'hf};
	logic [NIn-1:0] syncA_r, syncB_r;    // Two-stage pin synchroniser
	logic [7:0]     ctlIn;
	logic [31:0]    adIn;
	logic [3:0]     cbeIn;
	logic           reqN, irqN, serrN, stsIn, audIn, cdA, cdB, vsA, vsB;
	logic [3:0]     divCnt_r;            // Card clock divider
	logic           tick;                // One cycle after each card clock rise
	logic           busIdle, xfer, start, endNow, abortNow;
	cbsbc_init_t    iSt_r;
	cbsbc_tgt_t     tSt_r;
	logic           iWrite_r, lockReq_r, claimed_r;
	logic [3:0]     iLen_r;              // Words still to present
	logic [7:0]     toCnt_r;             // No-claim clocks
	logic           frameN_r, irdyN_r, iOe_r, lockN_r, lockOe_r;
	logic           devselN_r, trdyN_r, stopN_r, tOe_r;
	logic           parO_r, parOe_r, perrN_r, perrOe_r, chkArm_r, chkPar_r;
	logic           frameD_r, stsD_r;
	logic [31:0]    fifoData;
	logic           fifoValid, fifoPop;
	assign {ctlIn, cbeIn, adIn, reqN, irqN, serrN, stsIn, audIn, cdA, cdB, vsA, vsB} = syncB_r;
	assign tick = (divCnt_r == 4'h1);
	assign busIdle = ctlIn[`CBSBC_FRAME] & ctlIn[`CBSBC_IRDY];
	assign xfer = ~irdyN_r & ~ctlIn[`CBSBC_TRDY] & ~ctlIn[`CBSBC_DEVSEL];
	assign start = tick & (iSt_r == I_IDLE) & reqBusy & lnk.busGrantN & busIdle
		& ctlIn[`CBSBC_LOCK];   // Another holder of the lock keeps us out
	// No claim within the timeout ends the cycle
	assign abortNow = ~claimed_r & ctlIn[`CBSBC_DEVSEL] & (toCnt_r == 8'(AbortClks - 1));
	// Stop with target_ready low still lets the presented word complete
	assign endNow = (xfer & (frameN_r | ~ctlIn[`CBSBC_STOP]))
		| (~ctlIn[`CBSBC_DEVSEL] & ~ctlIn[`CBSBC_STOP] & ctlIn[`CBSBC_TRDY]);
	// Pop exactly when a new word is presented, so no word is lost or sent twice
	assign fifoPop = tick & (iSt_r == I_DATA) & iWrite_r & fifoValid & (xfer | irdyN_r)
		& ~endNow & ~abortNow & (iLen_r != 4'h0);
	assign lnk.hCtlO = {parO_r, lockN_r, perrN_r, stopN_r, devselN_r, trdyN_r, irdyN_r, frameN_r};
	assign lnk.hCtlOe = {parOe_r, lockOe_r, perrOe_r, {3{tOe_r}}, {2{iOe_r}}};
	assign lnk.hCbeOe = iOe_r;

	// Presence, voltage and card kind from the four detect/sense lines
	function automatic cbsbc_volt_t voltDecode(input logic a, input logic b);
		unique case ({b, a})
			2'b11: return V_5V;
			2'b10: return V_3V3;
			2'b01: return V_LOW;
			2'b00: return V_NONE;
		endcase
	endfunction

	cbsbc_fifo #(
		.Width(`CBSBC_DW),
		.Depth(`CBSBC_FIFO_DEPTH)
	) u_wrFifo (
		.clk      (sys_clk),
		.rst_n    (rst_n),
		.inData   (wrData),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// Pins pass two flops before anything reads them
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// Idle levels, so no false status edge follows reset
			syncA_r <= SyncIdle;
			syncB_r <= SyncIdle;
		end else begin
			syncA_r <= {lnk.ctlBus, lnk.commandByteEnable, lnk.cardAddrData, lnk.busRequestN,
				lnk.cardIrqN, lnk.cardSystemErrorN, lnk.cardStatusChange, lnk.cardAudioIn,
				lnk.cardDetectA, lnk.cardDetectB, lnk.voltageSenseA, lnk.voltageSenseB};
			syncB_r <= syncA_r;
		end
	end

	// Card clock: high for the first half of the count; outputs move one cycle after rise
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			divCnt_r <= '0;
			lnk.cardClock <= 1'b0;
		end else begin
			divCnt_r <= (divCnt_r == 4'(DivN - 1)) ? 4'h0 : divCnt_r + 4'h1;
			lnk.cardClock <= (divCnt_r < 4'(DivN / 2));
		end
	end

	// Sideband levels and events
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{speakerOut, cardPresent, cardIsCardbus, cardIrq, systemError} <= 5'h0;
			{statusChange, wakeUp, stsD_r} <= 3'h0;
			cardVolt <= V_NONE;
		end else begin
			speakerOut <= audIn;
			cardPresent <= ~cdA & ~cdB;
			cardVolt <= (~cdA & ~cdB) ? voltDecode(vsA, vsB) : V_NONE;
			cardIsCardbus <= ~cdA & ~cdB & (vsA ^ vsB);
			cardIrq <= ~irqN;
			systemError <= ~serrN;
			stsD_r <= stsIn;
			statusChange <= stsIn & ~stsD_r;
			wakeUp <= stsIn;
		end
	end

	// Arbiter: grant given only between transactions, withdrawn as soon as the request drops
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lnk.busGrantN <= 1'b1;
		end else if (tick) begin
			if (reqN) begin
				lnk.busGrantN <= 1'b1;
			end else if (iSt_r == I_IDLE && !start && busIdle && !reqBusy) begin
				lnk.busGrantN <= 1'b0;
			end
		end
	end

	// Initiator: address phase, then words from the FIFO or into rdData
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			iSt_r <= I_IDLE;
			{reqBusy, iWrite_r, lockReq_r, claimed_r, rdValid, doneOk, doneAbort} <= 7'h0;
			{frameN_r, irdyN_r, lockN_r, iOe_r, lockOe_r, lnk.hAdOe} <= 6'h38;
			iLen_r <= '0;
			toCnt_r <= '0;
			lnk.hAdO <= '0;
			lnk.hCbeO <= 4'hf;
			rdData <= '0;
		end else begin
			rdValid <= 1'b0;
			doneOk <= 1'b0;
			doneAbort <= 1'b0;
			if (reqValid && !reqBusy) begin
				reqBusy <= 1'b1;
				iWrite_r <= reqWrite;
				lockReq_r <= reqLock;
				iLen_r <= reqLen;
				lnk.hAdO <= reqAddr;
			end
			if (tick) begin
				unique case (iSt_r)
					I_IDLE: if (start) begin
						frameN_r <= 1'b0;
						{iOe_r, lnk.hAdOe} <= 2'b11;
						lnk.hCbeO <= iWrite_r ? `CBSBC_CMD_WR : `CBSBC_CMD_RD;
						lockN_r <= ~lockReq_r;
						lockOe_r <= lockReq_r;
						iSt_r <= I_ADDR;
					end
					I_ADDR: begin
						lnk.hCbeO <= `CBSBC_BE_ALL;
						lnk.hAdOe <= iWrite_r;
						{claimed_r, toCnt_r} <= '0;
						iSt_r <= I_DATA;
					end
					I_DATA: begin
						claimed_r <= claimed_r | ~ctlIn[`CBSBC_DEVSEL];
						toCnt_r <= toCnt_r + 8'h1;
						if (xfer && !iWrite_r) begin
							rdData <= adIn;
							rdValid <= 1'b1;
						end
						if (abortNow) begin
							{frameN_r, irdyN_r} <= 2'b11;
							doneAbort <= 1'b1;
							iSt_r <= I_TURN;
						end else if (endNow) begin
							{frameN_r, irdyN_r} <= 2'b11;
							doneOk <= 1'b1;
							iSt_r <= I_TURN;
						end else if (xfer || irdyN_r) begin
							// Present the next word or insert a wait state
							if (!iWrite_r || fifoValid) begin
								irdyN_r <= 1'b0;
								lnk.hAdO <= fifoData;
								iLen_r <= iLen_r - 4'h1;
								frameN_r <= (iLen_r == 4'h1);
							end else begin
								irdyN_r <= 1'b1;
							end
						end
					end
					I_TURN: begin
						{iOe_r, lnk.hAdOe, lockOe_r} <= 3'h0;
						lockN_r <= 1'b1;
						reqBusy <= 1'b0;
						iSt_r <= I_IDLE;
					end
				endcase
			end
		end
	end

	// Target: claim single-word writes in our window, then disconnect
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tSt_r <= T_IDLE;
			{devselN_r, trdyN_r, stopN_r, tOe_r, tgtValid, frameD_r} <= 6'h39;
			{chkArm_r, chkPar_r} <= 2'h0;
			tgtAddr <= '0;
			tgtData <= '0;
		end else begin
			tgtValid <= 1'b0;
			if (tick) begin
				frameD_r <= ctlIn[`CBSBC_FRAME];
				chkArm_r <= 1'b0;
				unique case (tSt_r)
					T_IDLE: if (!ctlIn[`CBSBC_FRAME] && frameD_r && iSt_r == I_IDLE
						&& cbeIn == `CBSBC_CMD_WR && adIn[31:28] == `CBSBC_HOST_WIN) begin
						{devselN_r, trdyN_r, stopN_r, tOe_r} <= 4'h1;
						tgtAddr <= adIn;
						tSt_r <= T_WAIT;
					end
					T_WAIT: begin
						if (!ctlIn[`CBSBC_IRDY]) begin
							tgtData <= adIn;
							tgtValid <= 1'b1;
							chkArm_r <= (cbeIn != `CBSBC_CMD_SPECIAL);
							chkPar_r <= cbsbc_parity(adIn, cbeIn);
						end
						if (!ctlIn[`CBSBC_IRDY] || busIdle) begin
							{devselN_r, trdyN_r, stopN_r} <= 3'h7;
							tSt_r <= T_DONE;
						end
					end
					T_DONE: begin
						tOe_r <= 1'b0;
						tSt_r <= T_IDLE;
					end
					default: tSt_r <= T_IDLE;
				endcase
			end
		end
	end

	// Parity out one clock behind its data; error low two clocks after data
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{parO_r, parOe_r, perrN_r, perrOe_r, parityErr} <= 5'h04;
		end else begin
			parityErr <= 1'b0;
			if (tick) begin
				parO_r <= cbsbc_parity(lnk.hAdO, lnk.hCbeO);
				parOe_r <= lnk.hAdOe;
				perrOe_r <= chkArm_r;
				perrN_r <= ~(chkArm_r && ctlIn[`CBSBC_PAR] != chkPar_r);
				parityErr <= chkArm_r && ctlIn[`CBSBC_PAR] != chkPar_r;
			end
		end
	end
endmodule

// [cbsbc_params.svh]
// Timing counts, bit positions and bus codes of the socket bus control block
`ifndef CBSBC_PARAMS_SVH
`define CBSBC_PARAMS_SVH
`define CBSBC_SYS_NS 100
`define CBSBC_CARD_CLOCK_NS 800
`define CBSBC_DIV (`CBSBC_CARD_CLOCK_NS / `CBSBC_SYS_NS)
`define CBSBC_ABORT_CLKS 5
`define CBSBC_FIFO_DEPTH 16
`define CBSBC_DW 32
`define CBSBC_FRAME 0
`define CBSBC_IRDY 1
`define CBSBC_TRDY 2
`define CBSBC_DEVSEL 3
`define CBSBC_STOP 4
`define CBSBC_PERR 5
`define CBSBC_LOCK 6
`define CBSBC_PAR 7
`define CBSBC_NCTL 8
`define CBSBC_CMD_SPECIAL 4'h1
`define CBSBC_CMD_RD 4'h6
`define CBSBC_CMD_WR 4'h7
`define CBSBC_BE_ALL 4'h0
`define CBSBC_HOST_WIN 4'h8
`define CBSBC_CARD_WIN 4'h4
`endif

// [cbsbc_pkg.sv]
// Types and the parity helper shared by both ends of the socket link
package cbsbc_pkg;
	// Controller initiator states
	typedef enum logic [1:0] {
		I_IDLE = 2'b00,
		I_ADDR = 2'b01,
		I_DATA = 2'b10,
		I_TURN = 2'b11
	} cbsbc_init_t;
	// Controller target states
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_WAIT = 2'b01,
		T_DONE = 2'b10
	} cbsbc_tgt_t;
	// Card end states
	typedef enum logic [2:0] {
		C_IDLE  = 3'b000,
		C_REQ   = 3'b001,
		C_IADDR = 3'b010,
		C_IDATA = 3'b011,
		C_TAR   = 3'b100,
		C_TURN  = 3'b101
	} cbsbc_card_t;
	// Operating voltage found from the sense lines
	typedef enum logic [1:0] {
		V_NONE = 2'b00,
		V_5V   = 2'b01,
		V_3V3  = 2'b10,
		V_LOW  = 2'b11
	} cbsbc_volt_t;
	// Even parity over data and command/byte-enable lines
	function automatic logic cbsbc_parity(input logic [31:0] ad, input logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction
endpackage

// [cbsbc_link_if.sv]
// Socket link wires: per-end drive and enable, resolved shared lines
`timescale 1ns/1ps
interface cbsbc_link_if;
	logic [7:0]  hCtlO, hCtlOe, cCtlO, cCtlOe;  // Control drive and enable per end
	logic [7:0]  ctlBus;                        // Resolved control lines
	logic [31:0] hAdO, cAdO, cardAddrData;      // Address/data drive and resolved
	logic        hAdOe, cAdOe;                  // Address/data enables
	logic [3:0]  hCbeO, cCbeO, commandByteEnable;
	logic        hCbeOe, cCbeOe;
	logic        cardClock;                     // Made by the controller
	logic        busGrantN;
	logic        busRequestN;
	logic        cardIrqN;
	logic        cardSystemErrorN;
	logic        cardStatusChange;
	logic        cardAudioIn;
	logic        cardDetectA, cardDetectB;
	logic        voltageSenseA, voltageSenseB;
	// Undriven lines float high through pull-ups
	assign ctlBus = (hCtlO | ~hCtlOe) & (cCtlO | ~cCtlOe);
	assign cardAddrData = (hAdOe ? hAdO : 32'hffffffff) & (cAdOe ? cAdO : 32'hffffffff);
	assign commandByteEnable = (hCbeOe ? hCbeO : 4'hf) & (cCbeOe ? cCbeO : 4'hf);
	modport host (
		output hCtlO, hCtlOe, hAdO, hAdOe, hCbeO, hCbeOe, cardClock, busGrantN,
		input ctlBus, cardAddrData, commandByteEnable, busRequestN, cardIrqN,
		input cardSystemErrorN, cardStatusChange, cardAudioIn, cardDetectA,
		input cardDetectB, voltageSenseA, voltageSenseB
	);
	modport card (
		output cCtlO, cCtlOe, cAdO, cAdOe, cCbeO, cCbeOe, busRequestN, cardIrqN,
		output cardSystemErrorN, cardStatusChange, cardAudioIn, cardDetectA,
		output cardDetectB, voltageSenseA, voltageSenseB,
		input ctlBus, cardAddrData, commandByteEnable, cardClock, busGrantN
	);
endinterface

// [cbsbc_fifo.sv]
// Write-data FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cbsbc_fifo #(
	parameter int Width = 32,
	parameter int Depth = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [Width-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [Width-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int Aw = $clog2(Depth);
	logic [Width-1:0] mem [Depth];   // Storage array
	logic [Aw-1:0]    wrPtr_r, rdPtr_r;
	logic [Aw:0]      cnt_r, cnt_nxt;
	logic             push, pop;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outValid = (cnt_r != '0);
	assign outData = mem[rdPtr_r];
	assign cnt_nxt = cnt_r + (Aw+1)'(push) - (Aw+1)'(pop);
	// Pointers, count and a registered ready so the filler sees back-pressure
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			cnt_r <= '0;
			inReady <= 1'b0;
		end else begin
			wrPtr_r <= push ? wrPtr_r + 1'b1 : wrPtr_r;
			rdPtr_r <= pop ? rdPtr_r + 1'b1 : rdPtr_r;
			cnt_r <= cnt_nxt;
			inReady <= (cnt_nxt != (Aw+1)'(Depth));
		end
	end
	// Storage has no reset, it is only read below the count
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end
endmodule

// [cbsbc_card_end.sv]
// Card end of the socket link: one-word target, one-word write initiator
`timescale 1ns/1ps
`include "cbsbc_params.svh"
module cbsbc_card_end
	import cbsbc_pkg::*;
#(
	parameter int AbortClks = `CBSBC_ABORT_CLKS
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	cbsbc_link_if.card       lnk,
	input  wire logic        wrReqValid,
	input  wire logic [31:0] wrReqAddr,
	input  wire logic [31:0] wrReqData,
	output logic             wrBusy,
	output logic             wrDoneOk,
	output logic             wrDoneAbort,
	output logic [31:0]      regData,
	output logic             parityErr,
	input  wire logic        detectA,
	input  wire logic        detectB,
	input  wire logic        senseA,
	input  wire logic        senseB,
	input  wire logic        irqReq,
	input  wire logic        sysErr,
	input  wire logic        statusChg,
	input  wire logic        audio
);
	localparam int NIn = 46;
	logic [NIn-1:0] syncA_r, syncB_r;   // Two-stage pin synchroniser
	logic           clkD_r, tick;       // Card clock edge finder
	logic [7:0]     ctlIn;
	logic [31:0]    adIn;
	logic [3:0]     cbeIn;
	logic           frameD_r, addrPhase, hit;
	cbsbc_card_t    st_r;
	logic [7:0]     toCnt_r;
	logic [3:0]     cmd_r;
	logic           frameN_r, irdyN_r, devselN_r, trdyN_r, stopN_r, ctlOe_r, tgtOe_r;
	logic           parO_r, parOe_r, perrN_r, perrOe_r, chkArm_r, chkPar_r;
	assign {ctlIn, cbeIn, adIn} = syncB_r[NIn-1:2];
	assign tick = syncB_r[1] & ~clkD_r;
	assign addrPhase = ~ctlIn[`CBSBC_FRAME] & frameD_r;
	assign hit = addrPhase & (adIn[31:28] == `CBSBC_CARD_WIN)
		& (cbeIn == `CBSBC_CMD_RD || cbeIn == `CBSBC_CMD_WR);
	assign lnk.cCtlO = {parO_r, 1'b1, perrN_r, stopN_r, devselN_r, trdyN_r, irdyN_r, frameN_r};
	assign lnk.cCtlOe = {parOe_r, 1'b0, perrOe_r, {3{tgtOe_r}}, {2{ctlOe_r}}};
	// Pins pass two flops; clkD_r reads only the second stage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncA_r <= '1;
			syncB_r <= '1;
			clkD_r <= 1'b1;
		end else begin
			syncA_r <= {lnk.ctlBus, lnk.commandByteEnable, lnk.cardAddrData, lnk.cardClock,
				lnk.busGrantN};
			syncB_r <= syncA_r;
			clkD_r <= syncB_r[1];
		end
	end
	// Sideband levels from the card's own logic
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lnk.cardDetectA <= 1'b1;
			lnk.cardDetectB <= 1'b1;
			lnk.voltageSenseA <= 1'b1;
			lnk.voltageSenseB <= 1'b1;
			lnk.cardIrqN <= 1'b1;
			lnk.cardSystemErrorN <= 1'b1;
			lnk.cardStatusChange <= 1'b0;
			lnk.cardAudioIn <= 1'b0;
		end else begin
			lnk.cardDetectA <= detectA;
			lnk.cardDetectB <= detectB;
			lnk.voltageSenseA <= senseA;
			lnk.voltageSenseB <= senseB;
			lnk.cardIrqN <= ~irqReq;
			lnk.cardSystemErrorN <= ~sysErr;
			lnk.cardStatusChange <= statusChg;
			lnk.cardAudioIn <= audio;
		end
	end
	// Both roles share one machine, the card is never both at once
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= C_IDLE;
			{frameN_r, irdyN_r, devselN_r, trdyN_r, stopN_r} <= 5'h1f;
			{ctlOe_r, tgtOe_r, lnk.cAdOe, lnk.cCbeOe} <= 4'h0;
			lnk.cAdO <= '0;
			lnk.cCbeO <= 4'hf;
			lnk.busRequestN <= 1'b1;
			{wrBusy, wrDoneOk, wrDoneAbort} <= 3'h0;
			{frameD_r, chkArm_r, chkPar_r} <= 3'h4;
			toCnt_r <= '0;
			cmd_r <= '0;
			regData <= '0;
		end else begin
			wrDoneOk <= 1'b0;
			wrDoneAbort <= 1'b0;
			if (wrReqValid && !wrBusy) begin
				wrBusy <= 1'b1;
			end
			if (tick) begin
				frameD_r <= ctlIn[`CBSBC_FRAME];
				chkArm_r <= 1'b0;
				unique case (st_r)
					C_IDLE, C_REQ: begin
						if (hit) begin
							// Claim for one word and disconnect at once
							{devselN_r, trdyN_r, stopN_r, tgtOe_r} <= 4'h1;
							cmd_r <= cbeIn;
							lnk.cAdO <= regData;
							lnk.cAdOe <= (cbeIn == `CBSBC_CMD_RD);
							st_r <= C_TAR;
						end else if (st_r == C_IDLE && wrBusy) begin
							lnk.busRequestN <= 1'b0;
							st_r <= C_REQ;
						end else if (st_r == C_REQ && !syncB_r[0]
							&& ctlIn[`CBSBC_FRAME] && ctlIn[`CBSBC_IRDY]) begin
							frameN_r <= 1'b0;
							{ctlOe_r, lnk.cAdOe, lnk.cCbeOe} <= 3'h7;
							lnk.cAdO <= wrReqAddr;
							lnk.cCbeO <= `CBSBC_CMD_WR;
							lnk.busRequestN <= 1'b1;
							st_r <= C_IADDR;
						end
					end
					C_IADDR: begin
						// Single word: frame drops as ready rises
						{frameN_r, irdyN_r} <= 2'b10;
						lnk.cAdO <= wrReqData;
						lnk.cCbeO <= `CBSBC_BE_ALL;
						toCnt_r <= '0;
						st_r <= C_IDATA;
					end
					C_IDATA: begin
						toCnt_r <= toCnt_r + 8'h1;
						if (!ctlIn[`CBSBC_DEVSEL] && !ctlIn[`CBSBC_TRDY]) begin
							wrDoneOk <= 1'b1;
							irdyN_r <= 1'b1;
							st_r <= C_TURN;
						end else if ((!ctlIn[`CBSBC_DEVSEL] && !ctlIn[`CBSBC_STOP])
							|| (ctlIn[`CBSBC_DEVSEL] && toCnt_r == 8'(AbortClks - 1))) begin
							wrDoneAbort <= 1'b1;
							irdyN_r <= 1'b1;
							st_r <= C_TURN;
						end
					end
					C_TAR: begin
						if (!ctlIn[`CBSBC_IRDY]) begin
							// Word moves on ready from both sides
							if (cmd_r == `CBSBC_CMD_WR) begin
								regData <= adIn;
								chkArm_r <= 1'b1;
								chkPar_r <= cbsbc_parity(adIn, cbeIn);
							end
							{devselN_r, trdyN_r, stopN_r} <= 3'h7;
							st_r <= C_TURN;
						end else if (ctlIn[`CBSBC_FRAME]) begin
							{devselN_r, trdyN_r, stopN_r} <= 3'h7;
							st_r <= C_TURN;
						end
					end
					C_TURN: begin
						{ctlOe_r, tgtOe_r, lnk.cAdOe, lnk.cCbeOe} <= 4'h0;
						if (!frameN_r || wrDoneOk || wrDoneAbort || st_r == C_TURN) begin
							wrBusy <= wrBusy & ~(ctlOe_r);
						end
						st_r <= C_IDLE;
					end
					default: st_r <= C_IDLE;
				endcase
			end
		end
	end
	// Parity one clock late, error report two clocks after the data
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{parO_r, parOe_r, perrN_r, perrOe_r, parityErr} <= 5'h04;
		end else begin
			parityErr <= 1'b0;
			if (tick) begin
				// As target the byte enables come from the initiator
				parO_r <= cbsbc_parity(lnk.cAdO, lnk.cCbeOe ? lnk.cCbeO : cbeIn);
				parOe_r <= lnk.cAdOe;
				perrOe_r <= chkArm_r;
				perrN_r <= ~(chkArm_r && ctlIn[`CBSBC_PAR] != chkPar_r);
				parityErr <= chkArm_r && ctlIn[`CBSBC_PAR] != chkPar_r;
			end
		end
	end
endmodule

// [cbsbc_link_properties.sv]
// Assertions on the shared socket wires
`timescale 1ns/1ps
module cbsbc_link_properties (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [7:0] ctlBus,
	input wire logic [3:0] commandByteEnable,
	input wire logic       cardClock,
	input wire logic       busGrantN,
	input wire logic       busRequestN
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_hi4; cardClock [*4]; endsequence  // High half of a card clock
	sequence s_lo; !cardClock; endsequence
	sequence s_open; $fell(ctlBus[0]); endsequence  // Frame opens a transaction
	a_lock_framed: assert property (
		$fell(ctlBus[6]) |-> s_open) else $error("lock outside frame");
	a_lock_release: assert property (
		$rose(ctlBus[6]) |-> ctlBus[0]) else $error("lock dropped in frame");
	a_clock_shape: assert property (
		$rose(cardClock) |-> s_hi4 ##1 s_lo) else $error("card clock shape");
	a_grant_idle: assert property (
		$fell(busGrantN) |-> ctlBus[0]) else $error("grant in frame");
	a_grant_asked: assert property (
		$fell(busGrantN) |-> !busRequestN) else $error("grant unasked");
	a_ready_claimed: assert property (
		!ctlBus[2] |-> !ctlBus[3]) else $error("ready unclaimed");
	a_last_ready: assert property (
		$rose(ctlBus[0]) |-> !ctlBus[1]) else $error("frame end idle");
	a_stop_ends: assert property (
		!ctlBus[4] |-> ##[0:24] ctlBus[0]) else $error("stop ignored");
	a_command_ok: assert property (
		$fell(ctlBus[0]) |-> commandByteEnable inside {4'h6, 4'h7}) else $error("bad cmd");
	a_no_perr: assert property (
		ctlBus[5]) else $error("parity error");
endmodule

// [cardbus_socket_bus_control_tb.sv]
// Bench joining both socket ends over one link
`timescale 1ns/1ps
module cardbus_socket_bus_control_tb;
	logic        sys_clk, rst_n, reqValid, reqWrite, wrValid, wrReqValid, stSeen, lk;
	logic        reqBusy, wrReady, rdValid, doneOk, doneAbort, tgtValid, wrBusy;
	logic        wrDoneOk, wrDoneAbort, spk, present, isCb, irq, sErr, stChg;
	logic [3:0]  side, det;  // Card levels {audio,irq,serr,status}, {detA,detB,senseA,senseB}
	logic [31:0] reqAddr, wrData, wrReqAddr, wrReqData, rdData, regData, tgtAddr, tgtData;
	logic [31:0] rdSeen, tA, tD;
	int          fails, n_compared;
	cbsbc_link_if cbsbc_link_if_inst ();
	cbsbc_host_end cbsbc_host_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.lnk(cbsbc_link_if_inst.host), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqLock(lk), .reqAddr(reqAddr), .reqLen(4'h1), .reqBusy(reqBusy),
		.wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData),
		.rdValid(rdValid), .doneOk(doneOk), .doneAbort(doneAbort), .tgtAddr(tgtAddr),
		.tgtData(tgtData), .tgtValid(tgtValid), .parityErr(), .speakerOut(spk),
		.cardPresent(present), .cardVolt(), .cardIsCardbus(isCb), .cardIrq(irq),
		.systemError(sErr), .statusChange(stChg), .wakeUp());
	cbsbc_card_end cbsbc_card_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.lnk(cbsbc_link_if_inst.card), .wrReqValid(wrReqValid), .wrReqAddr(wrReqAddr),
		.wrReqData(wrReqData), .wrBusy(wrBusy), .wrDoneOk(wrDoneOk),
		.wrDoneAbort(wrDoneAbort), .regData(regData), .parityErr(), .detectA(det[3]),
		.detectB(det[2]), .senseA(det[1]), .senseB(det[0]), .irqReq(side[2]),
		.sysErr(side[1]), .statusChg(side[0]), .audio(side[3]));
	cbsbc_link_properties cbsbc_link_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.ctlBus(cbsbc_link_if_inst.ctlBus), .cardClock(cbsbc_link_if_inst.cardClock),
		.commandByteEnable(cbsbc_link_if_inst.commandByteEnable),
		.busGrantN(cbsbc_link_if_inst.busGrantN), .busRequestN(cbsbc_link_if_inst.busRequestN));
	// Latch one-cycle pulses so tasks may judge them later
	always @(posedge sys_clk) begin
		if (rdValid) rdSeen <= rdData;
		if (tgtValid) {tA, tD} <= {tgtAddr, tgtData};
		if (stChg) stSeen <= 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Poll for a done pulse, then wait until the end goes idle
	task automatic wait_done(input bit card, output logic [1:0] r);
		r = 2'b00;
		while (r === 2'b00) begin
			r = card ? {wrDoneAbort, wrDoneOk} : {doneAbort, doneOk};
			tick(1);
		end
		while ((card ? wrBusy : reqBusy) !== 1'b0) tick(1);
	endtask
	task automatic hreq(input logic w, input logic [31:0] a, output logic [1:0] r);
		{reqWrite, reqAddr, reqValid} = {w, a, 1'b1};
		tick(1);
		reqValid = 1'b0;
		wait_done(1'b0, r);
	endtask
	task automatic bus_request(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		{wrReqAddr, wrReqData, wrReqValid} = {a, d, 1'b1};
		tick(1);
		wrReqValid = 1'b0;
		wait_done(1'b1, r);
	endtask
	// Card levels reach the host; both polarities are tried
	task automatic t_side;
		for (int v = 0; v < 2; v++) begin
			side = {4{v[0]}};
			tick(8);
			chk("spk irq serr", {3{v[0]}}, {spk, irq, sErr});
		end
		chk("present kind status", 3'b111, {present, isCb, stSeen});
		$display("side done");
	endtask
	// Fill past full, then drain one word per write; the extra word must never land
	task automatic t_fifo;
		logic [1:0] r;
		for (int i = 0; i < 17; i++) begin
			{wrData, wrValid} = {32'h5a000000 + i, 1'b1};
			tick(1);
		end
		wrValid = 1'b0;
		chk("fifo full", 0, wrReady);
		for (int i = 0; i < 16; i++) begin
			hreq(1'b1, 32'h40000010, r);
			chk("host write", 2'b01, r);
			chk("card word", 32'h5a000000 + i, regData);
		end
		$display("fifo done");
	endtask
	// Read back, unclaimed read, card writes mapped and unmapped
	task automatic t_link;
		logic [1:0] r;
		lk = 1'b1;
		hreq(1'b0, 32'h40000010, r);
		lk = 1'b0;
		chk("locked read", 32'h5a00000f, rdSeen);
		hreq(1'b0, 32'h00000000, r);
		chk("no claim", 2'b10, r);
		bus_request(32'h80000020, 32'h1234abcd, r);
		chk("card write", 2'b01, r);
		chk("host got", {32'h80000020, 32'h1234abcd}, {tA, tD});
		bus_request(32'h20000000, 32'h0, r);
		chk("card abort", 2'b10, r);
		$display("link done");
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Whole run is under a thousand cycles; this allows about thirty times that
	initial begin
		#3000000;
		fails++;
		print_verdict;
	end
	initial begin
		{rst_n, reqValid, reqWrite, wrValid, wrReqValid, stSeen, lk, side, det} = 0;
		det = 4'b0001;
		{reqAddr, wrData, wrReqAddr, wrReqData} = 0;
		tick(16);
		rst_n = 1'b1;
		t_side;
		t_fifo;
		t_link;
		print_verdict;
	end
endmodule
